// ===== verilog/cable_reflectometry_capture.sv
// Cable reflectometry pulse launch, windowed peak and threshold capture
`timescale 1ns/1ps
module cable_reflectometry_capture (
  input wire logic sys_clk, // System clock, 50 MHz
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic [4:0] regAddr, // Register address
  input wire logic [15:0] regWrData, // Register write data
  input wire logic regWrEn, // Write strobe
  input wire logic regRdEn, // Read strobe
  output logic [15:0] regRdData, // Read data, cycle after strobe
  input wire logic [5:0] sampleData, // Offset-coded line sample
  output logic diagnosticEnable, // Port in diagnostic condition
  output logic fastTransmitterSelect, // Use fast transmitter
  output logic sendOnRxPair, // Pulse sent on receive pair
  output logic monitorRxPair, // Response taken from receive pair
  output logic pulseDrive, // Test pulse being driven
  output logic pulseNegative, // Polarity of driven pulse
  output logic captureBusy // Capture in progress
);
  import crcap_pkg::*;

  // ----------------------------------------------------------------------
  // Control and window registers
  // ----------------------------------------------------------------------
  crcap_ctrl_t ctrl_reg, ctrl_next;
  crcap_win_t win_reg, win_next;
  crcap_state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [5:0] peakVal_reg, peakVal_next;
  logic [7:0] peakTime_reg, peakTime_next;
  logic peakSeen_reg, peakSeen_next;
  logic thrMet_reg, thrMet_next;
  logic [7:0] thrTime_reg, thrTime_next;
  logic [15:0] rdData_reg, rdData_next;
  logic arm, inWindow, captLast, beyondThr, betterPeak;
  logic ctrlWrite;

  assign ctrlWrite = regWrEn && regAddr == ADDR_CTRL;
  assign arm = ctrlWrite && regWrData[LAUNCH_BIT] && state_reg == ST_IDLE;
  assign inWindow = state_reg == ST_CAPT &&
    cnt_reg >= win_reg.windowStartTime &&
    cnt_reg <= win_reg.windowStopTime;
  assign captLast = state_reg == ST_CAPT &&
    (cnt_reg == win_reg.windowStopTime || cnt_reg == TIME_LAST);

  always_comb begin
    ctrl_next = ctrl_reg;
    win_next = win_reg;
    if (ctrlWrite) begin
      ctrl_next = crcap_ctrl_t'(regWrData);
      ctrl_next.reserved = 1'b0;
      if (state_reg == ST_CAPT) begin
        ctrl_next.launchPulse = 1'b1;
      end
    end
    if (captLast) begin
      ctrl_next.launchPulse = 1'b0;
    end
    if (regWrEn && regAddr == ADDR_WIN) begin
      win_next = crcap_win_t'(regWrData);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= '{threshold: THR_RESET, default: '0};
      win_reg <= '{windowStartTime: WIN_START_RESET,
                   windowStopTime: WIN_STOP_RESET};
    end else begin
      ctrl_reg <= ctrl_next;
      win_reg <= win_next;
    end
  end

  // ----------------------------------------------------------------------
  // Capture sequence and detection
  // ----------------------------------------------------------------------
  always_comb begin
    if (ctrl_reg.negativePeakSelect) begin
      beyondThr = sampleData < ctrl_reg.threshold;
      betterPeak = sampleData < peakVal_reg;
    end else begin
      beyondThr = sampleData > ctrl_reg.threshold;
      betterPeak = sampleData > peakVal_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    peakVal_next = peakVal_reg;
    peakTime_next = peakTime_reg;
    peakSeen_next = peakSeen_reg;
    thrMet_next = thrMet_reg;
    thrTime_next = thrTime_reg;
    case (state_reg)
      ST_IDLE: begin
        if (arm) begin
          state_next = ST_CAPT;
          cnt_next = 8'h00;
          peakVal_next = 6'h00;
          peakTime_next = 8'h00;
          peakSeen_next = 1'b0;
          thrMet_next = 1'b0;
          thrTime_next = 8'h00;
        end
      end
      ST_CAPT: begin
        if (inWindow) begin
          if (!peakSeen_reg || betterPeak) begin
            peakVal_next = sampleData;
            peakTime_next = cnt_reg;
            peakSeen_next = 1'b1;
          end
          if (beyondThr && !thrMet_reg) begin
            thrMet_next = 1'b1;
            thrTime_next = cnt_reg;
          end
        end
        if (captLast) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      peakVal_reg <= 6'h00;
      peakTime_reg <= 8'h00;
      peakSeen_reg <= 1'b0;
      thrMet_reg <= 1'b0;
      thrTime_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      peakVal_reg <= peakVal_next;
      peakTime_reg <= peakTime_next;
      peakSeen_reg <= peakSeen_next;
      thrMet_reg <= thrMet_next;
      thrTime_reg <= thrTime_next;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    rdData_next = 16'h0000;
    if (regRdEn) begin
      case (regAddr)
        ADDR_CTRL: rdData_next = ctrl_reg;
        ADDR_WIN: rdData_next = win_reg;
        ADDR_PEAK: rdData_next = {2'h0, peakVal_reg, peakTime_reg};
        ADDR_THR: rdData_next = {7'h00, thrMet_reg, thrTime_reg};
        default: rdData_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdData_reg <= 16'h0000;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------------
  crcap_pulse_gen u_pulse (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .startPulse(arm),
    .fastTx(regWrData[14]),
    .widthUnits(regWrData[10:8]),
    .pulseDrive(pulseDrive),
    .pulseNegative(pulseNegative)
  );

  assign regRdData = rdData_reg;
  assign diagnosticEnable = ctrl_reg.diagnosticEnable;
  assign fastTransmitterSelect = ctrl_reg.fastTransmitterSelect;
  assign sendOnRxPair = ctrl_reg.sendOnRxPair;
  assign monitorRxPair = ctrl_reg.monitorRxPair;
  assign captureBusy = state_reg == ST_CAPT ? 1'b1 : 1'b0;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  AST_BUSY_LAUNCH: assert property (
    state_reg == ST_CAPT |-> ctrl_reg.launchPulse)
    else $error("send bit low during capture");

  AST_SELF_CLEAR: assert property (
    captLast |=> !ctrl_reg.launchPulse && state_reg == ST_IDLE)
    else $error("send bit not cleared at end of capture");

  AST_ARM_CLEAR: assert property (
    arm |=> peakVal_reg == 6'h00 && !thrMet_reg && cnt_reg == 8'h00)
    else $error("results not cleared on arm");

  AST_COUNT_STEP: assert property (
    state_reg == ST_CAPT && !captLast |=> cnt_reg == $past(cnt_reg) + 8'h01)
    else $error("sample time did not advance");

  AST_OUT_WINDOW: assert property (
    state_reg == ST_CAPT && !inWindow
      |=> $stable(peakVal_reg) && $stable(thrMet_reg))
    else $error("result changed outside window");

  AST_THR_FIRST: assert property (
    inWindow && beyondThr && !thrMet_reg
      |=> thrMet_reg && thrTime_reg == $past(cnt_reg))
    else $error("threshold hit not recorded");

  AST_PEAK_FIRST: assert property (
    inWindow && peakSeen_reg && sampleData == peakVal_reg
      |=> $stable(peakTime_reg))
    else $error("equal sample moved peak time");

  AST_NEG_THR: assert property (
    inWindow && ctrl_reg.negativePeakSelect &&
      sampleData >= ctrl_reg.threshold && !thrMet_reg |=> !thrMet_reg)
    else $error("threshold met without strict crossing");

  AST_RSV_ZERO: assert property (
    regRdEn && regAddr == ADDR_THR |=> regRdData[15:9] == 7'h00)
    else $error("reserved threshold bits not zero");

  AST_THR_SET: assert property (
    inWindow && !ctrl_reg.negativePeakSelect &&
      sampleData > ctrl_reg.threshold |=> thrMet_reg)
    else $error("threshold crossing not flagged");

  AST_THR_HOLD: assert property (
    thrMet_reg && state_reg == ST_CAPT
      |=> thrMet_reg && $stable(thrTime_reg))
    else $error("threshold time moved after first hit");

  AST_MAX_LOAD: assert property (
    inWindow && peakSeen_reg && !ctrl_reg.negativePeakSelect &&
      sampleData > peakVal_reg |=> peakVal_reg == $past(sampleData))
    else $error("larger sample not taken as peak");

  AST_MIN_KEEP: assert property (
    inWindow && peakSeen_reg && ctrl_reg.negativePeakSelect &&
      sampleData > peakVal_reg |=> $stable(peakVal_reg))
    else $error("larger sample taken in negative peak mode");

  AST_FIRST_LOAD: assert property (
    inWindow && !peakSeen_reg
      |=> peakSeen_reg && peakTime_reg == $past(cnt_reg))
    else $error("first windowed sample not loaded");

  AST_CTRL_RSV: assert property (
    regRdEn && regAddr == ADDR_CTRL |=> regRdData[6] == 1'b0)
    else $error("reserved control bit not zero");

  AST_PEAK_RSV: assert property (
    regRdEn && regAddr == ADDR_PEAK |=> regRdData[15:14] == 2'h0)
    else $error("reserved peak bits not zero");

  AST_WIN_HOLD: assert property (
    !(regWrEn && regAddr == ADDR_WIN) |=> $stable(win_reg))
    else $error("window changed without a write");

  AST_PULSE_START: assert property (
    arm && regWrData[10:8] != 3'h0 |=> pulseDrive)
    else $error("pulse not launched on arm");

  AST_ENABLE_OUT: assert property (
    ctrlWrite |=> diagnosticEnable == $past(regWrData[15]))
    else $error("diagnostic enable not taken from write");

endmodule

// ===== verilog/crcap_pkg.sv
// Shared constants and types for the cable reflectometry capture block
package crcap_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [4:0] ADDR_CTRL = 5'h16;
  localparam logic [4:0] ADDR_WIN = 5'h17;
  localparam logic [4:0] ADDR_PEAK = 5'h18;
  localparam logic [4:0] ADDR_THR = 5'h19;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int LAUNCH_BIT = 11;
  localparam logic [5:0] THR_RESET = 6'h20;
  localparam logic [7:0] WIN_START_RESET = 8'h00;
  localparam logic [7:0] WIN_STOP_RESET = 8'hff;
  localparam logic [7:0] TIME_LAST = 8'hff;

  // ----------------------------------------------------------------------
  // Pulse timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int FAST_UNIT_NS = 8;
  localparam int SLOW_SHORT_NS = 50;
  localparam int SLOW_FULL_NS = 100;
  localparam logic [7:0] FAST_UNIT_CYC =
    8'((FAST_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SLOW_SHORT_CYC =
    8'((SLOW_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SLOW_FULL_CYC =
    8'((SLOW_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic diagnosticEnable;
    logic fastTransmitterSelect;
    logic sendOnRxPair;
    logic monitorRxPair;
    logic launchPulse;
    logic [2:0] pulseWidth;
    logic negativePeakSelect;
    logic reserved;
    logic [5:0] threshold;
  } crcap_ctrl_t;

  typedef struct packed {
    logic [7:0] windowStartTime;
    logic [7:0] windowStopTime;
  } crcap_win_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CAPT = 1'b1
  } crcap_state_t;

endpackage

// ===== verilog/crcap_pulse_gen.sv
// Test pulse generator for the cable reflectometry capture block
`timescale 1ns/1ps
module crcap_pulse_gen (
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic startPulse, // One-cycle launch request
  input wire logic fastTx, // Fast transmitter selected
  input wire logic [2:0] widthUnits, // Pulse width in units
  output logic pulseDrive, // Pulse is being driven
  output logic pulseNegative // Polarity of the driven pulse
);
  import crcap_pkg::*;

  // ----------------------------------------------------------------------
  // Pulse length and polarity
  // ----------------------------------------------------------------------
  logic [7:0] cnt_reg, cnt_next, pulseLen;
  logic drive_reg, drive_next, neg_reg, neg_next, alt_reg, alt_next;

  always_comb begin
    if (fastTx) begin
      pulseLen = 8'(widthUnits * FAST_UNIT_CYC);
    end else if (widthUnits == 3'h1) begin
      pulseLen = SLOW_SHORT_CYC;
    end else begin
      pulseLen = SLOW_FULL_CYC;
    end
    cnt_next = cnt_reg;
    drive_next = drive_reg;
    neg_next = neg_reg;
    alt_next = alt_reg;
    if (startPulse && widthUnits != 3'h0) begin
      cnt_next = pulseLen;
      drive_next = 1'b1;
      neg_next = fastTx & alt_reg;
      if (fastTx) begin
        alt_next = ~alt_reg;
      end
    end else if (drive_reg) begin
      if (cnt_reg <= 8'h01) begin
        drive_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 8'h00;
      drive_reg <= 1'b0;
      neg_reg <= 1'b0;
      alt_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      drive_reg <= drive_next;
      neg_reg <= neg_next;
      alt_reg <= alt_next;
    end
  end

  assign pulseDrive = drive_reg;
  assign pulseNegative = neg_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_ZERO_WIDTH: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    startPulse && widthUnits == 3'h0 && !drive_reg |=> !pulseDrive)
    else $error("pulse driven with zero width");

  AST_SLOW_SHORT: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    startPulse && !fastTx && widthUnits == 3'h1
      |=> pulseDrive [*3] ##1 !pulseDrive)
    else $error("short slow pulse has wrong length");

  AST_ALTERNATE: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    startPulse && fastTx && widthUnits != 3'h0 |=> alt_reg != $past(alt_reg))
    else $error("fast pulse polarity did not alternate");

endmodule

// ===== testbench/tb.sv
// Self-checking bench for the cable reflectometry capture block
`timescale 1ns/1ps
module tb;
  import crcap_pkg::*;

  // ----------------------------------------------------------------------
  // Case table
  // ----------------------------------------------------------------------
  typedef struct {
    logic neg;
    logic fast;
    logic [2:0] width;
    logic [5:0] thr;
    logic [7:0] start;
    logic [7:0] stop;
    logic [15:0] peak;
    logic [15:0] thrRes;
    int pulses;
    logic pulseNeg;
  } crcap_row_t;

  crcap_row_t rows [6] = '{
    '{1'b0, 1'b0, 3'h1, 6'h28, 8'h00, 8'h07, 16'h3a02, 16'h0102, 3, 1'b0},
    '{1'b1, 1'b0, 3'h2, 6'h18, 8'h00, 8'h07, 16'h0505, 16'h0103, 5, 1'b0},
    '{1'b0, 1'b1, 3'h3, 6'h3a, 8'h03, 8'h05, 16'h3a04, 16'h0000, 3, 1'b0},
    '{1'b1, 1'b0, 3'h1, 6'h20, 8'h00, 8'h02, 16'h2000, 16'h0000, 3, 1'b0},
    '{1'b0, 1'b1, 3'h7, 6'h3f, 8'h07, 8'h07, 16'h2007, 16'h0000, 7, 1'b1},
    '{1'b0, 1'b0, 3'h0, 6'h28, 8'h05, 8'h02, 16'h0000, 16'h0000, 0, 1'b0}
  };
  logic [5:0] smp [8] = '{6'h20, 6'h25, 6'h3a, 6'h10,
                          6'h3a, 6'h05, 6'h30, 6'h20};

  logic sys_clk;
  logic rstn;
  logic [4:0] regAddr;
  logic [15:0] regWrData;
  logic regWrEn;
  logic regRdEn;
  logic [15:0] regRdData;
  logic [5:0] sampleData;
  logic diagnosticEnable;
  logic fastTransmitterSelect;
  logic sendOnRxPair;
  logic monitorRxPair;
  logic pulseDrive;
  logic pulseNegative;
  logic captureBusy;
  int n_mismatch;
  int n_compared;

  cable_reflectometry_capture i_cable_reflectometry_capture (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .sampleData(sampleData),
    .diagnosticEnable(diagnosticEnable),
    .fastTransmitterSelect(fastTransmitterSelect),
    .sendOnRxPair(sendOnRxPair),
    .monitorRxPair(monitorRxPair),
    .pulseDrive(pulseDrive),
    .pulseNegative(pulseNegative),
    .captureBusy(captureBusy)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(negedge sys_clk);
    chk(regRdData, exp);
  endtask

  function automatic logic [15:0] ctrl_pins();
    return {12'h000, diagnosticEnable, fastTransmitterSelect,
            sendOnRxPair, monitorRxPair};
  endfunction

  // Arms one capture and feeds the sample pattern aligned to the arm edge
  task automatic run_row(input crcap_row_t r, input logic [1:0] pairs);
    logic [15:0] ctrl;
    int pc;
    int bc;
    logic firstNeg;
    ctrl = {1'b1, r.fast, pairs, 1'b1, r.width, r.neg, 1'b0, r.thr};
    pc = 0;
    bc = 0;
    firstNeg = 1'b0;
    wr(ADDR_WIN, {r.start, r.stop});
    wr(ADDR_CTRL, ctrl);
    for (int c = 0; c < 20; c++) begin
      sampleData <= (c < 8) ? smp[c] : 6'h20;
      @(negedge sys_clk);
      if (pulseDrive === 1'b1) begin
        if (pc == 0) firstNeg = pulseNegative;
        pc++;
      end
      if (captureBusy === 1'b1) bc++;
      @(posedge sys_clk);
    end
    chk(16'(pc), 16'(r.pulses));
    chk(16'(bc), 16'(r.stop) + 16'h0001);
    chk({15'h0000, firstNeg}, {15'h0000, r.pulseNeg});
    chk(ctrl_pins(), {12'h000, 1'b1, r.fast, pairs});
    rd(ADDR_CTRL, ctrl & 16'hf7ff);
    rd(ADDR_PEAK, r.peak);
    rd(ADDR_THR, r.thrRes);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    regAddr = 5'h00;
    regWrData = 16'h0000;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    sampleData = 6'h20;
    n_mismatch = 0;
    n_compared = 0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      run_row(rows[i], 2'(i));
    end
    // Reserved, read-only and unmapped places
    wr(ADDR_CTRL, 16'hf7ff);
    rd(ADDR_CTRL, 16'hf7bf);
    @(negedge sys_clk);
    chk(regRdData, 16'h0000);
    chk(ctrl_pins(), 16'h000f);
    wr(ADDR_PEAK, 16'hffff);
    rd(ADDR_PEAK, 16'h0000);
    wr(ADDR_THR, 16'hffff);
    rd(ADDR_THR, 16'h0000);
    wr(5'h1a, 16'hffff);
    rd(5'h1a, 16'h0000);
    rd(5'h15, 16'h0000);
    // Control write with send low during a capture does not stop it
    wr(ADDR_WIN, 16'h0007);
    wr(ADDR_CTRL, 16'h0920);
    wr(ADDR_CTRL, 16'h0120);
    rd(ADDR_CTRL, 16'h0920);
    chk({15'h0000, captureBusy}, 16'h0001);
    repeat (8) @(posedge sys_clk);
    rd(ADDR_CTRL, 16'h0120);
    // Reset in mid-run after a capture left results behind
    run_row(rows[0], 2'h3);
    wr(ADDR_WIN, 16'h1234);
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(ctrl_pins(), 16'h0000);
    chk({14'h0000, pulseDrive, captureBusy}, 16'h0000);
    rstn <= 1'b1;
    rd(ADDR_CTRL, 16'h0020);
    rd(ADDR_WIN, 16'h00ff);
    rd(ADDR_PEAK, 16'h0000);
    rd(ADDR_THR, 16'h0000);
    print_verdict();
  end

  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule
